/* File: rtl/acsr_pkg.sv */
package acsr_pkg;
   localparam int CLK_SYS_MHZ = 200;
   localparam int CONV_NS = 5000;
   localparam int WAKE_NS = 5000;
   localparam int CONV_CYC = (CONV_NS * CLK_SYS_MHZ + 999) / 1000;
   localparam int WAKE_CYC = (WAKE_NS * CLK_SYS_MHZ + 999) / 1000;
   localparam int TMR_W = 12;
   localparam int RES_W = 14;
   localparam int FRAME_W = 16;
   localparam int CNT_W = 4;
   localparam logic [1:0] LEAD_ZEROS = 2'h0;
   localparam logic [CNT_W-1:0] CNT_LAST = 4'hF;
   localparam logic [CNT_W-1:0] BIT_TOP = 4'hE;

   typedef struct packed {
      logic [1:0] lead;
      logic [RES_W-1:0] code;
   } acsr_frame_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_CONV = 3'h1,
      ST_PUSH = 3'h2,
      ST_PDOWN = 3'h3,
      ST_WAKE = 3'h4
   } acsr_state_t;
endpackage : acsr_pkg

/* File: rtl/acsr_buf2.sv */
`timescale 1ns/1ps
module acsr_buf2 #(
   parameter int W = 16
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] mem_q [2];
   logic [W-1:0] mem_d [2];
   logic wr_q, wr_d, rd_q, rd_d;
   logic [1:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = in_data;
         wr_d = ~wr_q;
      end
      if (pop) begin
         rd_d = ~rd_q;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 2'h1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 2'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      mem_q <= mem_d;
      if (srst) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end
endmodule : acsr_buf2

/* File: rtl/acsr_top.sv */
`timescale 1ns/1ps
module acsr_top (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic sclk,
   input wire logic conversion_start_n,
   input wire logic bipolar_range,
   input wire logic [acsr_pkg::RES_W-1:0] core_code,
   output logic busy,
   output logic power_down,
   output logic serial_data_out,
   output logic serial_data_oe_n
);
   import acsr_pkg::*;

   // ==========================================================
   // Pin and link done-toggle synchronisers, system side
   // ==========================================================
   logic cs_s1_q, cs_s2_q, cs_s3_q;
   logic bip_s1_q, bip_s2_q;
   logic dn_s1_q, dn_s2_q, dn_s3_q;
   logic done_tgl_q;
   logic cs_fall, cs_rise, frame_done;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         bip_s1_q <= 1'b0;
         bip_s2_q <= 1'b0;
         dn_s1_q <= 1'b0;
         dn_s2_q <= 1'b0;
         dn_s3_q <= 1'b0;
      end else begin
         cs_s1_q <= conversion_start_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         bip_s1_q <= bipolar_range;
         bip_s2_q <= bip_s1_q;
         dn_s1_q <= done_tgl_q;
         dn_s2_q <= dn_s1_q;
         dn_s3_q <= dn_s2_q;
      end
   end

   assign cs_fall = cs_s3_q & ~cs_s2_q;
   assign cs_rise = ~cs_s3_q & cs_s2_q;
   assign frame_done = dn_s3_q ^ dn_s2_q;

   // ==========================================================
   // Conversion control
   // ==========================================================
   acsr_state_t st_q, st_d;
   logic [TMR_W-1:0] tmr_q, tmr_d;
   logic [RES_W-1:0] held_q, held_d;
   logic busy_q, busy_d;
   logic pd_q, pd_d;
   logic pend_q, pend_d;
   logic buf_in_ready, buf_in_valid;
   acsr_frame_t res_word;

   // Core delivers offset binary; bipolar ranges flip the top bit
   always_comb begin
      res_word.lead = LEAD_ZEROS;
      res_word.code = held_q;
      if (bip_s2_q) begin
         res_word.code[RES_W-1] = ~held_q[RES_W-1];
      end
   end

   assign buf_in_valid = (st_q == ST_PUSH);

   always_comb begin
      st_d = st_q;
      tmr_d = tmr_q;
      held_d = held_q;
      busy_d = busy_q;
      pd_d = pd_q;
      pend_d = pend_q;
      case (st_q)
         ST_IDLE: begin
            if (cs_fall) begin
               held_d = core_code;
               busy_d = 1'b1;
               tmr_d = TMR_W'(CONV_CYC - 1);
               st_d = ST_CONV;
            end
         end
         ST_CONV: begin
            if (tmr_q == '0) begin
               st_d = ST_PUSH;
            end else begin
               tmr_d = tmr_q - 1'b1;
            end
         end
         ST_PUSH: begin
            if (buf_in_ready) begin
               busy_d = 1'b0;
               if (!cs_s2_q) begin
                  pd_d = 1'b1;
                  st_d = ST_PDOWN;
               end else begin
                  st_d = ST_IDLE;
               end
            end
         end
         ST_PDOWN: begin
            if (cs_rise) begin
               pd_d = 1'b0;
               pend_d = 1'b0;
               tmr_d = TMR_W'(WAKE_CYC - 1);
               st_d = ST_WAKE;
            end
         end
         ST_WAKE: begin
            // A start during wake-up is held until the core is awake
            if (cs_fall && !pend_q) begin
               held_d = core_code;
               busy_d = 1'b1;
               pend_d = 1'b1;
            end
            if (tmr_q == '0) begin
               if (pend_q || cs_fall) begin
                  tmr_d = TMR_W'(CONV_CYC - 1);
                  st_d = ST_CONV;
               end else begin
                  st_d = ST_IDLE;
               end
            end else begin
               tmr_d = tmr_q - 1'b1;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_q <= ST_IDLE;
         tmr_q <= '0;
         held_q <= '0;
         busy_q <= 1'b0;
         pd_q <= 1'b0;
         pend_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         held_q <= held_d;
         busy_q <= busy_d;
         pd_q <= pd_d;
         pend_q <= pend_d;
      end
   end

   assign busy = busy_q;
   assign power_down = pd_q;

   // ==========================================================
   // Result buffer and frame hand-off
   // ==========================================================
   logic buf_out_valid, buf_out_ready;
   logic [FRAME_W-1:0] buf_out_data;
   acsr_frame_t frame_q, frame_d;
   logic oe_n_q, oe_n_d;

   acsr_buf2 #(
      .W(FRAME_W)
   ) u_buf (
      .clk_sys(clk_sys),
      .srst(srst),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(res_word),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   // Frame word only changes while the line is released and the link is idle
   assign buf_out_ready = oe_n_q & ~frame_done;

   always_comb begin
      frame_d = frame_q;
      oe_n_d = oe_n_q;
      if (frame_done) begin
         oe_n_d = 1'b1;
      end else if (buf_out_valid && oe_n_q) begin
         frame_d = acsr_frame_t'(buf_out_data);
         oe_n_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         frame_q <= '0;
         oe_n_q <= 1'b1;
      end else begin
         frame_q <= frame_d;
         oe_n_q <= oe_n_d;
      end
   end

   assign serial_data_oe_n = oe_n_q;

   // ==========================================================
   // Link side, clocked by falling serial clock edges
   // ==========================================================
   logic lr_s1_q, lr_s2_q;
   logic [CNT_W-1:0] bit_cnt_q, bit_cnt_d;
   logic sdo_q, sdo_d;
   logic done_tgl_d;

   always_comb begin
      bit_cnt_d = bit_cnt_q + 1'b1;
      done_tgl_d = done_tgl_q;
      sdo_d = 1'b0;
      if (bit_cnt_q == CNT_LAST) begin
         // Last bit: line stays low, release follows via the system side
         done_tgl_d = ~done_tgl_q;
      end else begin
         sdo_d = frame_q[BIT_TOP - bit_cnt_q];
      end
   end

   always_ff @(negedge sclk) begin
      lr_s1_q <= srst;
      lr_s2_q <= lr_s1_q;
      if (lr_s2_q) begin
         bit_cnt_q <= '0;
         sdo_q <= 1'b0;
         done_tgl_q <= 1'b0;
      end else begin
         bit_cnt_q <= bit_cnt_d;
         sdo_q <= sdo_d;
         done_tgl_q <= done_tgl_d;
      end
   end

   assign serial_data_out = sdo_q;
endmodule : acsr_top

/* File: testbench/acsr_properties.sv */
`timescale 1ns/1ps
// ==========
// Checker
module acsr_properties (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic sclk,
   input wire logic conversion_start_n,
   input wire logic bipolar_range,
   input wire logic [acsr_pkg::RES_W-1:0] core_code,
   input wire logic busy,
   input wire logic power_down,
   input wire logic serial_data_out,
   input wire logic serial_data_oe_n
);
   import acsr_pkg::*;
   int since_q;
   int blen_q;
   logic pin_q;
   logic done_q;
   logic [4:0] nf_q;
   always_ff @(posedge clk_sys) begin
      pin_q <= conversion_start_n;
      since_q <= (srst || (pin_q && !conversion_start_n)) ? 0 : since_q + 1;
      blen_q <= busy ? blen_q + 1 : 0;
   end
   // Falls of the link clock within a frame
   always_ff @(negedge sclk) begin
      if (srst) begin
         nf_q <= 5'h0;
         done_q <= 1'b0;
      end else if (!serial_data_oe_n) begin
         nf_q <= (nf_q == 5'hF) ? 5'h0 : nf_q + 5'h1;
         done_q <= done_q ^ (nf_q == 5'hF);
      end
   end
   a_reset_idle: assert property (@(posedge clk_sys)
      srst |=> !busy && !power_down && serial_data_oe_n) else $error("not idle after reset");
   a_busy_cause: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(busy) |-> since_q inside {[2:6]}) else $error("busy without start");
   a_busy_start: assert property (@(posedge clk_sys) disable iff (srst)
      $fell(conversion_start_n) && !busy && !power_down |-> ##[1:6] busy)
      else $error("start ignored");
   a_conv_time: assert property (@(posedge clk_sys) disable iff (srst)
      $fell(busy) |-> blen_q >= CONV_CYC - 1) else $error("conversion too short");
   a_pdown_entry: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(power_down) |-> $fell(busy)) else $error("power-down not at end");
   a_pdown_exit: assert property (@(posedge clk_sys) disable iff (srst)
      power_down && conversion_start_n |-> ##[1:6] !power_down) else $error("no wake");
   a_lead_zeros: assert property (@(negedge sclk) disable iff (srst)
      !serial_data_oe_n && nf_q < 5'h2 |-> !serial_data_out) else $error("lead bit set");
   a_line_release: assert property (@(posedge clk_sys) disable iff (srst)
      $changed(done_q) |-> ##[1:6] serial_data_oe_n) else $error("line not released");
endmodule : acsr_properties

bind acsr_top acsr_properties u_props (.clk_sys(clk_sys), .srst(srst), .sclk(sclk),
   .conversion_start_n(conversion_start_n), .bipolar_range(bipolar_range),
   .core_code(core_code), .busy(busy), .power_down(power_down),
   .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n));

/* File: testbench/acsr_host.sv */
`timescale 1ns/1ps
// ==========
// Host reading frames
module acsr_host (
   output logic sclk,
   input wire logic sdo,
   input wire logic oe_n
);
   logic last_q = 1'b0;
   logic line;
   // Released line shows the inverse of the last driven bit
   assign line = oe_n ? ~last_q : sdo;
   always @(sdo or oe_n) if (!oe_n) last_q = sdo;
   initial sclk = 1'b0;
   task automatic read(output logic [15:0] w);
      w = 16'h0;
      #2.3;
      repeat (16) begin
         #40 sclk = 1'b1;
         #39 w = {w[14:0], line};
         #1 sclk = 1'b0;
      end
   endtask : read
   task automatic idle_clocks(input int n);
      repeat (n) begin
         #40 sclk = 1'b1;
         #40 sclk = 1'b0;
      end
   endtask : idle_clocks
endmodule : acsr_host

/* File: testbench/adc_conversion_serial_readout_bench.sv */
`timescale 1ns/1ps
// ==========
// Bench
module adc_conversion_serial_readout_bench;
   import acsr_pkg::*;
   logic clk_sys, srst, sclk, conversion_start_n, bipolar_range;
   logic [RES_W-1:0] core_code;
   logic busy, power_down, serial_data_out, serial_data_oe_n;
   logic [2:0] obs;
   int n_fail = 0;
   int total_checks = 0;
   int waited;
   assign obs = {serial_data_oe_n, power_down, busy};
   acsr_top DUT (.clk_sys(clk_sys), .srst(srst), .sclk(sclk),
      .conversion_start_n(conversion_start_n), .bipolar_range(bipolar_range),
      .core_code(core_code), .busy(busy), .power_down(power_down),
      .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n));
   acsr_host host (.sclk(sclk), .sdo(serial_data_out), .oe_n(serial_data_oe_n));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run;
      if (n_fail == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : complete_run
   task automatic wait_on(input int idx, input logic v, input int n);
      waited = 0;
      while (obs[idx] !== v) begin
         if (waited == n) begin
            n_fail++;
            complete_run();
         end
         waited++;
         @(posedge clk_sys);
      end
   endtask : wait_on
   task automatic start(input logic [13:0] code, input logic bip);
      @(posedge clk_sys);
      core_code <= code;
      bipolar_range <= bip;
      conversion_start_n <= 1'b0;
      wait_on(0, 1'b1, 20);
      check(16'(waited <= 6), 16'h1);
   endtask : start
   task automatic frame(input logic [13:0] code, input logic bip);
      logic [15:0] w;
      repeat (8) @(posedge clk_sys);
      wait_on(2, 1'b0, 3000);
      host.read(w);
      check(w, {2'b00, code ^ {bip, 13'h0}});
   endtask : frame
   task automatic sc_convert;
      logic [13:0] codes [4] = '{14'h0000, 14'h3FFF, 14'h2A5C, 14'h15A3};
      for (int i = 0; i < 4; i++) begin
         start(codes[i], i[0]);
         repeat (10) @(posedge clk_sys);
         conversion_start_n <= 1'b1;
         wait_on(0, 1'b0, 1100);
         check(16'(waited + 10 >= CONV_CYC), 16'h1);
         check({15'h0, power_down}, 16'h0);
         frame(codes[i], i[0]);
         repeat (70) @(posedge clk_sys);
      end
   endtask : sc_convert
   task automatic sc_pdown;
      int t;
      start(14'h1234, 1'b0);
      wait_on(0, 1'b0, 1100);
      check({15'h0, power_down}, 16'h1);
      conversion_start_n <= 1'b1;
      wait_on(1, 1'b0, 10);
      t = waited;
      repeat (4) @(posedge clk_sys);
      conversion_start_n <= 1'b0;
      wait_on(0, 1'b1, 20);
      check(16'(waited <= 6), 16'h1);
      t = t + 4 + waited;
      conversion_start_n <= 1'b1;
      wait_on(0, 1'b0, 2200);
      check(16'(t + waited >= WAKE_CYC + CONV_CYC), 16'h1);
      frame(14'h1234, 1'b0);
      frame(14'h1234, 1'b0);
   endtask : sc_pdown
   task automatic sc_buffer;
      for (int i = 0; i < 4; i++) begin
         start(14'(i + 5), 1'b0);
         repeat (10) @(posedge clk_sys);
         conversion_start_n <= 1'b1;
         if (i < 3) wait_on(0, 1'b0, 1100);
         repeat (70) @(posedge clk_sys);
      end
      repeat (1100) @(posedge clk_sys);
      check({15'h0, busy}, 16'h1);
      for (int i = 0; i < 4; i++) frame(14'(i + 5), 1'b0);
   endtask : sc_buffer
   initial begin
      srst = 1'b1;
      conversion_start_n = 1'b1;
      bipolar_range = 1'b0;
      core_code = 14'h0;
      host.idle_clocks(4);
      @(posedge clk_sys);
      srst <= 1'b0;
      // Link reset copy needs two falling edges to clear after release
      host.idle_clocks(2);
      sc_convert();
      sc_pdown();
      sc_buffer();
      complete_run();
   end
endmodule : adc_conversion_serial_readout_bench
